/* File: vmp_margin_ctrl.sv */
// vmp_margin_ctrl: one rail's margin and trim pwm controller.
// assumes vout_meas_in and rail_enable_in come from logic on sys_clk_in;
// the two general inputs are pins and are synchronised here.
//
// Overview of operation
// - fixed-duty mode holds the configured duty whenever not margining.
// - a control bit chooses whether ov/uv faults are ignored while margining.
// - a polarity bit says whether more duty means more or less voltage.
// - margining starts from the operation bit or an assigned general input.
// - one general input enables margining, the other chooses high or low.
// - margining drives pwm, 0% low to 100% high; tri mode idles hi-z.
// - margining is refused until the rail passed power-good-on once.
// - closed loop moves the duty one step every 500 us.
// - target or voltage beyond ov/uv limit shuts the rail unless ignored.
// - every setting is writable over the register port by any host.
// - active-trim mode tracks the nominal voltage while the rail is ready and not margining.
// - tri mode leaves the output undriven whenever not margining.
// - the pwm period is programmable, derived from the system clock.
`timescale 1ns/1ns
`default_nettype none

module vmp_margin_ctrl
    import vmp_pkg::*;
#(
    parameter int VW         = 12,
    parameter int DW         = 16,
    parameter int ADJ_CYCLES = ADJ_CYC
) (
    input  wire logic              sys_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output var  logic [DATA_W-1:0] reg_rdata_out,
    input  wire logic              rail_enable_in,
    input  wire logic [VW-1:0]     vout_meas_in,
    input  wire logic              general_input_pin_en_in,
    input  wire logic              general_input_pin_dir_in,
    output var  logic              margin_pulse_output_out,
    output var  logic              margin_pulse_output_oe_n_out,
    output var  logic              rail_shutdown_out,
    output var  logic              margining_out,
    output var  logic              fault_masked_out,
    output var  logic              irq_out
);

    // refuse widths the register port cannot carry
    if (DW != DATA_W || VW > DATA_W || VW < 2 || ADJ_CYCLES < 2
        || ADJ_CYCLES > 65536) begin : g_chk
        $error("vmp_margin_ctrl: unsupported parameter values");
    end

    typedef enum logic [2:0] {
        ST_OFF, ST_WAIT, ST_READY, ST_MARGIN, ST_FAULT
    } vmp_state_t;

    ////////////////////////////////////////////////////////////////////////
    // registers and signals
    logic [DATA_W-1:0] ctrl_r, period_r, init_r, fixed_r;
    logic [VW-1:0]     tgt_hi_r, tgt_lo_r, nominal_r;
    logic [VW-1:0]     ov_lim_r, uv_lim_r, pg_on_r;
    logic [IRQ_N-1:0]  irq_st_r, irq_en_r, irq_evt;
    logic [DW-1:0]     duty_r, cnt_r;
    logic [15:0]       tick_cnt_r;
    logic              tick_r, active_r, pulse_r, oe_n_r;
    logic              en_s1_r, en_s2_r, dir_s1_r, dir_s2_r;
    logic              req, req_r, high_sel, active, loop_run;
    logic              load_init, want_up, step_up, in_band;
    logic              over, under, fault_hit, ignore;
    logic [VW-1:0]     target;
    logic [1:0]        mode;
    logic              wr_ok;
    vmp_state_t        st_r, st_nxt;

    assign mode   = ctrl_r[C_MODE_LSB +: 2];
    assign ignore = ctrl_r[C_IGNORE];
    assign wr_ok  = reg_wr_in;

    ////////////////////////////////////////////////////////////////////////
    // register writes; any host writing the port is treated alike
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_r    <= CTRL_RST;
            period_r  <= PERIOD_RST;
            init_r    <= DUTY_RST;
            fixed_r   <= DUTY_RST;
            tgt_hi_r  <= '0;
            tgt_lo_r  <= '0;
            nominal_r <= '0;
            ov_lim_r  <= LIM_HI_RST[VW-1:0];
            uv_lim_r  <= '0;
            pg_on_r   <= '0;
            irq_en_r  <= '0;
        end else if (wr_ok) begin
            case (reg_addr_in)
                A_CTRL:    ctrl_r    <= reg_wdata_in;
                A_PERIOD:  period_r  <= reg_wdata_in;
                A_INIT:    init_r    <= reg_wdata_in;
                A_FIXED:   fixed_r   <= reg_wdata_in;
                A_TGT_HI:  tgt_hi_r  <= reg_wdata_in[VW-1:0];
                A_TGT_LO:  tgt_lo_r  <= reg_wdata_in[VW-1:0];
                A_NOMINAL: nominal_r <= reg_wdata_in[VW-1:0];
                A_OV_LIM:  ov_lim_r  <= reg_wdata_in[VW-1:0];
                A_UV_LIM:  uv_lim_r  <= reg_wdata_in[VW-1:0];
                A_PG_ON:   pg_on_r   <= reg_wdata_in[VW-1:0];
                A_IRQ_EN:  irq_en_r  <= reg_wdata_in[IRQ_N-1:0];
                default: ;
            endcase
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                A_CTRL:    reg_rdata_out <= ctrl_r;
                A_PERIOD:  reg_rdata_out <= period_r;
                A_INIT:    reg_rdata_out <= init_r;
                A_FIXED:   reg_rdata_out <= fixed_r;
                A_TGT_HI:  reg_rdata_out <= DATA_W'(tgt_hi_r);
                A_TGT_LO:  reg_rdata_out <= DATA_W'(tgt_lo_r);
                A_NOMINAL: reg_rdata_out <= DATA_W'(nominal_r);
                A_OV_LIM:  reg_rdata_out <= DATA_W'(ov_lim_r);
                A_UV_LIM:  reg_rdata_out <= DATA_W'(uv_lim_r);
                A_PG_ON:   reg_rdata_out <= DATA_W'(pg_on_r);
                A_STATUS:  reg_rdata_out <= {10'h000, high_sel,
                                             st_r == ST_FAULT,
                                             st_r == ST_WAIT,
                                             st_r >= ST_READY,
                                             active_r, !oe_n_r};
                A_DUTY:    reg_rdata_out <= duty_r;
                A_IRQ_ST:  reg_rdata_out <= DATA_W'(irq_st_r);
                A_IRQ_EN:  reg_rdata_out <= DATA_W'(irq_en_r);
                default:   reg_rdata_out <= '0;
            endcase
        end else begin
            reg_rdata_out <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // general input pins: two flops before anything looks at them
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_s1_r  <= 1'b0;
            en_s2_r  <= 1'b0;
            dir_s1_r <= 1'b0;
            dir_s2_r <= 1'b0;
        end else begin
            en_s1_r  <= general_input_pin_en_in;
            en_s2_r  <= en_s1_r;
            dir_s1_r <= general_input_pin_dir_in;
            dir_s2_r <= dir_s1_r;
        end
    end

    // margin request from the operation bit or the enable input
    assign req = ctrl_r[C_OP_MRG]
               | (ctrl_r[C_GPI_EN] & en_s2_r);
    // an assigned direction input overrides the operation bit
    assign high_sel = ctrl_r[C_GPI_DIR] ? dir_s2_r
                                        : ctrl_r[C_OP_HIGH];
    assign target = active ? (high_sel ? tgt_hi_r : tgt_lo_r)
                           : nominal_r;

    ////////////////////////////////////////////////////////////////////////
    // limit checks; a target outside the window trips before the rail does
    always_comb begin
        over  = (vout_meas_in > ov_lim_r)
              | (active & (target > ov_lim_r));
        under = (vout_meas_in < uv_lim_r)
              | (active & (target < uv_lim_r));
        fault_hit = (st_r == ST_READY || st_r == ST_MARGIN)
                  & (over | under)
                  & !(st_r == ST_MARGIN && ignore);
    end

    // rail state; power good must be seen once per enable
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_OFF:    if (rail_enable_in) st_nxt = ST_WAIT;
            ST_WAIT: begin
                if (!rail_enable_in) st_nxt = ST_OFF;
                else if (vout_meas_in >= pg_on_r) st_nxt = ST_READY;
            end
            ST_READY: begin
                if (!rail_enable_in) st_nxt = ST_OFF;
                else if (fault_hit) st_nxt = ST_FAULT;
                else if (req) st_nxt = ST_MARGIN;
            end
            ST_MARGIN: begin
                if (!rail_enable_in) st_nxt = ST_OFF;
                else if (fault_hit) st_nxt = ST_FAULT;
                else if (!req) st_nxt = ST_READY;
            end
            ST_FAULT:  if (!rail_enable_in) st_nxt = ST_OFF;
            default:   st_nxt = ST_OFF;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= ST_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign active   = (st_r == ST_MARGIN);
    assign loop_run = active
                    | (mode == MODE_TRIM && st_r == ST_READY);
    // hi-z pin handed to margining starts from the initial duty
    assign load_init = active & !active_r & (mode == MODE_TRI);

    ////////////////////////////////////////////////////////////////////////
    // 500 us adjustment tick; slow enough not to fight the converter loop
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == 16'(ADJ_CYCLES - 1)) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            tick_r     <= 1'b0;
        end
    end

    // error sign and dead band of one step
    assign want_up = vout_meas_in < target;
    assign in_band = ({1'b0, vout_meas_in} + 1'b1 >= {1'b0, target})
                   & ({1'b0, target} + 1'b1 >= {1'b0, vout_meas_in});
    assign step_up = ~(want_up ^ ctrl_r[C_POL_UP]);

    // duty: initial load, fixed hold, or one step per tick
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            duty_r <= DUTY_RST;
        end else if (load_init) begin
            duty_r <= init_r;
        end else if (!active && mode == MODE_FIXED) begin
            duty_r <= fixed_r;
        end else if (tick_r && loop_run && !in_band) begin
            if (step_up && duty_r < period_r) begin
                duty_r <= duty_r + 1'b1;
            end else if (!step_up && duty_r != '0) begin
                duty_r <= duty_r - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pwm: duty equal to period gives a steady high, zero a steady low;
    // periods below two are stretched to two
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r   <= '0;
            pulse_r <= 1'b0;
        end else begin
            if (period_r < DW'(PERIOD_MIN) ? cnt_r >= DW'(PERIOD_MIN - 1)
                                           : cnt_r + 1'b1 >= period_r) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
            pulse_r <= (cnt_r < duty_r);
        end
    end

    // drive enable: undriven only in tri mode outside margining
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            oe_n_r   <= 1'b1;
            active_r <= 1'b0;
            req_r    <= 1'b0;
        end else begin
            oe_n_r   <= !active && (mode == MODE_TRI);
            active_r <= active;
            req_r    <= req;
        end
    end

    assign margin_pulse_output_out      = pulse_r;
    assign margin_pulse_output_oe_n_out = oe_n_r;
    assign margining_out                = active_r;
    assign rail_shutdown_out            = (st_r == ST_FAULT);
    assign fault_masked_out = active_r & ignore & (over | under);

    ////////////////////////////////////////////////////////////////////////
    // sticky events; a set in the clear cycle wins
    always_comb begin
        irq_evt            = '0;
        irq_evt[I_START]   = active & !active_r;
        irq_evt[I_STOP]    = !active & active_r;
        irq_evt[I_FAULT]   = fault_hit;
        irq_evt[I_REFUSED] = req & !req_r & (st_r == ST_WAIT);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_st_r <= '0;
        end else begin
            irq_st_r <= (irq_st_r & ~((wr_ok && reg_addr_in == A_IRQ_CLR)
                        ? reg_wdata_in[IRQ_N-1:0] : '0)) | irq_evt;
        end
    end

    assign irq_out = |(irq_st_r & irq_en_r);

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_tri_hiz: assert property (
        !active && mode == MODE_TRI |=> margin_pulse_output_oe_n_out)
        else $error("margin pin driven while idle in tri mode");
    a_fixed_hold: assert property (
        !active && mode == MODE_FIXED && !load_init
        |=> duty_r == $past(fixed_r))
        else $error("fixed duty not held");
    a_pg_gate: assert property (
        st_r == ST_WAIT || st_r == ST_OFF |=> !margining_out)
        else $error("margining before power good");
    a_pwm_zero: assert property (
        $past(duty_r) == '0 |-> !margin_pulse_output_out)
        else $error("zero duty produced a pulse");
    a_pwm_full: assert property (
        $past(duty_r) >= $past(period_r) && $past(duty_r) >= DW'(PERIOD_MIN)
        |-> margin_pulse_output_out)
        else $error("full duty produced a low");
    a_tick_space: assert property (
        tick_r |=> !tick_r [*8])
        else $error("adjust ticks too close");
    a_duty_step: assert property (
        loop_run && !load_init && !tick_r |=> $stable(duty_r))
        else $error("duty moved between ticks");
    a_dir_polarity: assert property (
        tick_r && loop_run && !load_init && !in_band && step_up
        && duty_r < period_r |=> duty_r == $past(duty_r) + 1'b1)
        else $error("duty not stepped up");
    a_fault_stop: assert property (
        fault_hit && rail_enable_in |=> rail_shutdown_out [*2])
        else $error("fault did not shut the rail");
    a_ignore_mask: assert property (
        active && ignore |-> !fault_hit)
        else $error("fault taken while ignored");
    a_init_load: assert property (
        load_init |=> duty_r == $past(init_r))
        else $error("initial duty not loaded");
    a_gpi_start: assert property (
        st_r == ST_READY && ctrl_r[C_GPI_EN] && en_s2_r
        && rail_enable_in && !fault_hit |-> ##2 margining_out)
        else $error("enable input did not start margining");

endmodule : vmp_margin_ctrl

`default_nettype wire

/* File: vmp_margin_ctrl_tb.sv */
// vmp_margin_ctrl_tb: self-checking bench for the rail margin controller.
// assumes the rail model closes the loop; adjustment interval shortened.
`timescale 1ns/1ns
`default_nettype none

module vmp_margin_ctrl_tb;
    import vmp_pkg::*;
    localparam int ADJ = 20;
    logic              sys_clk = 1'b0;
    logic              rst_n   = 1'b0;
    logic [ADDR_W-1:0] addr    = '0;
    logic [DATA_W-1:0] wdata   = '0;
    logic              wr      = 1'b0;
    logic              rd      = 1'b0;
    logic              rail_en = 1'b0;
    logic              pin_en  = 1'b0;
    logic              pin_dir = 1'b0;
    logic              frc     = 1'b0;
    logic [11:0]       frc_val = 12'h100;
    logic [DATA_W-1:0] rdata, q;
    logic [11:0]       vout;
    logic              pulse, oe_n, shdn, mrg, fmask, irq;
    int                n_errors    = 0;
    int                checks_done = 0;
    int                n;
    // addr, write, data, readback
    logic [36:0]       rows [21] = '{
        {A_CTRL, 1'b0, 16'h0000, CTRL_RST}, {A_PERIOD, 1'b0, 16'h0, PERIOD_RST},
        {A_INIT, 1'b0, 16'h0000, DUTY_RST}, {A_FIXED, 1'b0, 16'h0000, DUTY_RST},
        {A_OV_LIM, 1'b0, 16'h0, {4'h0, LIM_HI_RST[11:0]}},
        {A_UV_LIM, 1'b0, 16'h0, ZERO_RST}, {A_STATUS, 1'b0, 16'h0, ZERO_RST},
        {A_PG_ON, 1'b0, 16'h0, ZERO_RST}, {A_DUTY, 1'b0, 16'h0000, DUTY_RST},
        {A_IRQ_EN, 1'b0, 16'h0, ZERO_RST}, {A_PERIOD, 1'b1, 16'h10, 16'h10},
        {A_INIT, 1'b1, 16'h0008, 16'h0008}, {A_FIXED, 1'b1, 16'h5, 16'h5},
        {A_TGT_HI, 1'b1, 16'h430, 16'h430}, {A_TGT_LO, 1'b1, 16'h410, 16'h410},
        {A_NOMINAL, 1'b1, 16'h420, 16'h420}, {A_PG_ON, 1'b1, 16'h300, 16'h300},
        {A_IRQ_EN, 1'b1, 16'h000F, 16'h000F}, {A_DUTY, 1'b1, 16'h3, DUTY_RST},
        {A_IRQ_CLR, 1'b1, 16'h000F, 16'h0000}, {4'hF, 1'b1, 16'h1234, 16'h0}};

    vmp_margin_ctrl #(.VW(12), .DW(16), .ADJ_CYCLES(ADJ)) vmp_margin_ctrl_inst (
        .sys_clk_in(sys_clk), .rst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .rail_enable_in(rail_en), .vout_meas_in(vout),
        .general_input_pin_en_in(pin_en), .general_input_pin_dir_in(pin_dir),
        .margin_pulse_output_out(pulse), .margin_pulse_output_oe_n_out(oe_n),
        .rail_shutdown_out(shdn), .margining_out(mrg),
        .fault_masked_out(fmask), .irq_out(irq));

    vmp_rail_model #(.VW(12), .WIN(16)) vmp_rail_model_inst (
        .sys_clk_in(sys_clk), .rst_n_in(rst_n), .rail_en_in(rail_en),
        .pulse_in(pulse), .oe_n_in(oe_n), .force_en_in(frc),
        .force_val_in(frc_val), .vout_out(vout));

    ////////////////////////////////////////////////////////////////////////
    // clock: 50 ns period
    always #25 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one-cycle strobes; any host may issue them back to back
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask : cyc

    // bounded wait so a stuck state machine cannot hang the run
    task automatic wait_mrg(input logic v);
        for (int i = 0; i < 60 && mrg !== v; i++) cyc(1);
        chk("margining", {15'h0, mrg}, {15'h0, v});
    endtask : wait_mrg

    task automatic duty_is(input logic [15:0] e);
        rd_reg(A_DUTY, q);
        chk("duty", q, e);
    endtask : duty_is

    // high cycles over one full pwm period of 16 clocks
    task automatic cnt_hi(output int c);
        c = 0;
        repeat (16) begin
            @(posedge sys_clk);
            #1 c += int'(pulse === 1'b1);
        end
    endtask : cnt_hi

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // watchdog well beyond the roughly 1600 cycles the tests need
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_errors++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(8);
        chk("oe_n in reset", {15'h0, oe_n}, 16'h1);
        chk("irq in reset", {15'h0, irq}, 16'h0);
        $display("test reset done");
        cyc(8);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][32]) wr_reg(rows[i][36:33], rows[i][31:16]);
            rd_reg(rows[i][36:33], q);
            chk("reg", q, rows[i][15:0]);
        end
        $display("test registers done");
        // margin asked before power good: refused, flagged, pin stays hi-z
        @(posedge sys_clk);
        rail_en <= 1'b1;
        frc     <= 1'b1;
        wr_reg(A_CTRL, 16'h0038);
        cyc(10);
        chk("margining early", {15'h0, mrg}, 16'h0);
        chk("oe_n idle", {15'h0, oe_n}, 16'h1);
        rd_reg(A_IRQ_ST, q);
        chk("irq refused", q, 16'h0008);
        chk("irq out", {15'h0, irq}, 16'h1);
        wr_reg(A_IRQ_CLR, 16'h0008);
        wr_reg(A_CTRL, 16'h0008);
        cyc(2);
        chk("irq cleared", {15'h0, irq}, 16'h0);
        $display("test refuse done");
        // power good reached, margin high by command, tri start at init
        @(posedge sys_clk);
        frc <= 1'b0;
        cyc(4);
        wr_reg(A_CTRL, 16'h0038);
        wait_mrg(1'b1);
        duty_is(16'h0008);
        chk("oe_n driven", {15'h0, oe_n}, 16'h0);
        for (int i = 0; i < 10; i++) begin
            n = int'(q);
            cyc(ADJ - 3);
            rd_reg(A_DUTY, q);
            chk("one step", 16'(int'(q) > n + 1 || n > int'(q) + 1),
                16'h0);
        end
        duty_is(16'h000C);
        $display("test margin high done");
        // input pins take over: margining stops, then the enable pin
        // restarts it from the ready state with direction low
        wr_reg(A_CTRL, 16'h00C8);
        @(posedge sys_clk);
        pin_en  <= 1'b1;
        pin_dir <= 1'b0;
        cyc(12 * ADJ);
        chk("still margining", {15'h0, mrg}, 16'h1);
        duty_is(16'h0004);
        @(posedge sys_clk);
        pin_en <= 1'b0;
        wait_mrg(1'b0);
        cyc(2);
        chk("oe_n released", {15'h0, oe_n}, 16'h1);
        rd_reg(A_IRQ_ST, q);
        chk("irq start stop", q, 16'h0003);
        $display("test input pins done");
        // inverted polarity: the loop must lower duty to raise voltage
        wr_reg(A_CTRL, 16'h0030);
        wait_mrg(1'b1);
        cyc(14 * ADJ);
        duty_is(16'h0000);
        $display("test polarity done");
        // fixed duty while idle, including the 0% and 100% ends
        wr_reg(A_CTRL, 16'h000A);
        wait_mrg(1'b0);
        cyc(20);
        duty_is(16'h0005);
        cnt_hi(n);
        chk("high count", 16'(n), 16'h0005);
        wr_reg(A_FIXED, 16'h0000);
        cyc(20);
        cnt_hi(n);
        chk("high count 0", 16'(n), 16'h0000);
        wr_reg(A_FIXED, 16'h0010);
        cyc(20);
        cnt_hi(n);
        chk("high count 100", 16'(n), 16'h0010);
        $display("test fixed done");
        // active trim walks back to the nominal voltage
        wr_reg(A_CTRL, 16'h0009);
        cyc(16 * ADJ);
        duty_is(16'h0008);
        $display("test trim done");
        // target above the ov limit: ignored, then acted on
        wr_reg(A_OV_LIM, 16'h0428);
        wr_reg(A_IRQ_CLR, 16'h000F);
        wr_reg(A_CTRL, 16'h003C);
        wait_mrg(1'b1);
        cyc(12 * ADJ);
        chk("no shutdown", {15'h0, shdn}, 16'h0);
        chk("fault masked", {15'h0, fmask}, 16'h1);
        wr_reg(A_CTRL, 16'h0038);
        cyc(4);
        chk("shutdown", {15'h0, shdn}, 16'h1);
        rd_reg(A_IRQ_ST, q);
        chk("irq fault", q & 16'h0004, 16'h0004);
        chk("irq out fault", {15'h0, irq}, 16'h1);
        @(posedge sys_clk);
        rail_en <= 1'b0;
        cyc(4);
        chk("shutdown cleared", {15'h0, shdn}, 16'h0);
        $display("test fault done");
        end_of_test();
    end
endmodule : vmp_margin_ctrl_tb

`default_nettype wire

/* File: vmp_pkg.sv */
// vmp_pkg: constants shared by the rail margin and trim controller.
// assumes one 20 MHz system clock and a 4-bit word-indexed register port.
`default_nettype none

package vmp_pkg;
    // register port geometry
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    // register indexes
    localparam logic [3:0] A_CTRL    = 4'h0;
    localparam logic [3:0] A_PERIOD  = 4'h1;
    localparam logic [3:0] A_INIT    = 4'h2;
    localparam logic [3:0] A_FIXED   = 4'h3;
    localparam logic [3:0] A_TGT_HI  = 4'h4;
    localparam logic [3:0] A_TGT_LO  = 4'h5;
    localparam logic [3:0] A_NOMINAL = 4'h6;
    localparam logic [3:0] A_OV_LIM  = 4'h7;
    localparam logic [3:0] A_UV_LIM  = 4'h8;
    localparam logic [3:0] A_PG_ON   = 4'h9;
    localparam logic [3:0] A_STATUS  = 4'hA;
    localparam logic [3:0] A_DUTY    = 4'hB;
    localparam logic [3:0] A_IRQ_ST  = 4'hC;
    localparam logic [3:0] A_IRQ_CLR = 4'hD;
    localparam logic [3:0] A_IRQ_EN  = 4'hE;

    // control register fields
    localparam int C_MODE_LSB = 0;
    localparam int C_IGNORE   = 2;
    localparam int C_POL_UP   = 3;
    localparam int C_OP_MRG   = 4;
    localparam int C_OP_HIGH  = 5;
    localparam int C_GPI_EN   = 6;
    localparam int C_GPI_DIR  = 7;

    // idle behaviour of the margin output
    localparam logic [1:0] MODE_TRI   = 2'h0;
    localparam logic [1:0] MODE_TRIM  = 2'h1;
    localparam logic [1:0] MODE_FIXED = 2'h2;

    // interrupt status bits
    localparam int IRQ_N       = 4;
    localparam int I_START     = 0;
    localparam int I_STOP      = 1;
    localparam int I_FAULT     = 2;
    localparam int I_REFUSED   = 3;

    // values after reset
    localparam logic [15:0] CTRL_RST   = 16'h0008;
    localparam logic [15:0] PERIOD_RST = 16'h0100;
    localparam logic [15:0] DUTY_RST   = 16'h0080;
    localparam logic [15:0] LIM_HI_RST = 16'hFFFF;
    localparam logic [15:0] ZERO_RST   = 16'h0000;

    // adjustment interval and minimum pwm period
    localparam int CLK_KHZ = 20000;
    localparam int ADJ_US  = 500;
    localparam int ADJ_CYC = ADJ_US * CLK_KHZ / 1000;
    localparam int PERIOD_MIN = 2;
endpackage : vmp_pkg

`default_nettype wire

/* File: vmp_rail_model.sv */
// vmp_rail_model: behavioural rail seen through the rc filter and converter.
// assumes one pwm period of the margin pin equals WIN system clocks.
`timescale 1ns/1ns
`default_nettype none

module vmp_rail_model
    import vmp_pkg::*;
#(
    parameter int          VW   = 12,
    parameter int          WIN  = 16,
    parameter logic [11:0] BASE = 12'h400,
    parameter logic [11:0] GAIN = 12'h004,
    parameter logic [11:0] IDLE = 12'h420
) (
    input  wire logic          sys_clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          rail_en_in,
    input  wire logic          pulse_in,
    input  wire logic          oe_n_in,
    input  wire logic          force_en_in,
    input  wire logic [VW-1:0] force_val_in,
    output var  logic [VW-1:0] vout_out
);
    logic [WIN-1:0] win_r;

    ////////////////////////////////////////////////////////////////////////
    // sliding window of the pin; equals the duty once a period has passed
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            win_r <= '0;
        end else begin
            win_r <= {win_r[WIN-2:0], pulse_in & ~oe_n_in};
        end
    end

    // hi-z leaves the feedback node at its own reference, hence IDLE
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vout_out <= '0;
        end else if (!rail_en_in) begin
            vout_out <= '0;
        end else if (force_en_in) begin
            vout_out <= force_val_in; // only where a scenario asks for it
        end else if (oe_n_in) begin
            vout_out <= IDLE;
        end else begin
            vout_out <= BASE + GAIN * VW'($countones(win_r));
        end
    end
endmodule : vmp_rail_model

`default_nettype wire
